// *** rtl/secl_loader.v ***
// How it works
// - after each reset, probe the two-wire port for a rom
// - valid header: load subsystem and vendor id word (offset fch)
// - valid header: load four general configuration bytes
// - bad header: abort, leave id and configuration unloaded
// - no rom: keep default power-up values, fully working
// - data line changes only while the clock is low
// - data edge with clock high is start or stop only
// - dummy write of address zero, repeated start, then read
// - start at byte zero, read sequentially byte after byte
// - valid header: exactly nine bytes are fetched, bad header: two
// - after power-up the host may read and write the rom; with the disable strap set each request ends in error
// - disable strap: skip boot read and release both pins
// - first config byte in bits 7:0, fourth in 31:24
`timescale 1ns/1ps
`include "secl_regs.vh"
module secl_loader #(
  parameter QTR_CYC = `SECL_QTR_CYC,
  parameter [31:0] DEF_SUBSYS = 32'h00000000,
  parameter [31:0] DEF_CONFIG = 32'h00000000
) (
  input wire CLK,
  input wire RST_N,
  input wire ROM_LOADER_DISABLE,
  input wire SERIAL_ROM_DATA_LINE_IN,
  output wire SERIAL_ROM_DATA_LINE_OUT,
  output wire SERIAL_ROM_DATA_LINE_OE,
  output wire SERIAL_ROM_CLOCK_LINE_OUT,
  output wire SERIAL_ROM_CLOCK_LINE_OE,
  input wire HOST_REQ,
  input wire HOST_WRITE,
  input wire [7:0] HOST_ADDR,
  input wire [7:0] HOST_WDATA,
  output wire HOST_READY,
  output wire HOST_DONE,
  output wire HOST_ERR,
  output wire [7:0] HOST_RDATA,
  output wire LOAD_DONE,
  output wire LOAD_VALID,
  output wire ROM_PRESENT,
  output wire [31:0] SUBSYSTEM_IDS,
  output wire [31:0] CONFIG_LOAD_REGISTER
);
  localparam [3:0] S_BOOT = 4'h0;
  localparam [3:0] S_START = 4'h1;
  localparam [3:0] S_DEVW = 4'h2;
  localparam [3:0] S_ADDR = 4'h3;
  localparam [3:0] S_WDAT = 4'h4;
  localparam [3:0] S_RSTART = 4'h5;
  localparam [3:0] S_DEVR = 4'h6;
  localparam [3:0] S_READ = 4'h7;
  localparam [3:0] S_STOP = 4'h8;
  localparam [3:0] S_IDLE = 4'h9;

  localparam [1:0] M_LOAD = 2'h0;
  localparam [1:0] M_RD = 2'h1;
  localparam [1:0] M_WR = 2'h2;

  function [31:0] put_byte;
    input [31:0] word;
    input [1:0] pos;
    input [7:0] b;
    begin
      put_byte = word;
      case (pos)
        2'h0: put_byte[7:0] = b;
        2'h1: put_byte[15:8] = b;
        2'h2: put_byte[23:16] = b;
        default: put_byte[31:24] = b;
      endcase
    end
  endfunction

  reg off_s1_reg;
  reg off_s2_reg;
  reg [3:0] state_reg;
  reg [1:0] mode_reg;
  reg [1:0] boot_reg;
  reg [3:0] idx_reg;
  reg [7:0] addr_reg;
  reg [7:0] wdat_reg;
  reg issued_reg;
  reg go_reg;
  reg [1:0] cmd_reg;
  reg [7:0] tx_reg;
  reg nack_reg;
  reg fail_reg;
  reg abort_reg;
  reg [31:0] sub_stage_reg;
  reg [31:0] cfg_stage_reg;
  reg [31:0] subsys_reg;
  reg [31:0] config_reg;
  reg load_done_reg;
  reg load_valid_reg;
  reg present_reg;
  reg ready_reg;
  reg host_done_reg;
  reg host_err_reg;
  reg [7:0] host_rdata_reg;

  reg [1:0] cmd_next;
  reg [7:0] tx_next;
  wire nack_next;
  wire eng_done;
  wire eng_ack;
  wire [7:0] eng_rx;
  wire [3:0] sub_pos;
  wire [3:0] cfg_pos;

  assign sub_pos = idx_reg - `SECL_SUB_IDX;
  assign cfg_pos = idx_reg - `SECL_CFG_IDX;

  // last of nine, any host byte, or the throwaway after a bad header
  assign nack_next = (mode_reg != M_LOAD) | abort_reg | (idx_reg == `SECL_LAST_IDX);

  assign HOST_READY = ready_reg;
  assign HOST_DONE = host_done_reg;
  assign HOST_ERR = host_err_reg;
  assign HOST_RDATA = host_rdata_reg;
  assign LOAD_DONE = load_done_reg;
  assign LOAD_VALID = load_valid_reg;
  assign ROM_PRESENT = present_reg;
  assign SUBSYSTEM_IDS = subsys_reg;
  assign CONFIG_LOAD_REGISTER = config_reg;

  secl_wire_engine #(
    .QTR_CYC(QTR_CYC)
  ) u_engine (
    .clk(CLK),
    .rst_n(RST_N),
    .pins_off(off_s2_reg),
    .cmd_valid(go_reg),
    .cmd(cmd_reg),
    .tx_byte(tx_reg),
    .tx_nack(nack_reg),
    .sda_pin(SERIAL_ROM_DATA_LINE_IN),
    .done(eng_done),
    .acked(eng_ack),
    .rx_byte(eng_rx),
    .scl_out(SERIAL_ROM_CLOCK_LINE_OUT),
    .scl_oe(SERIAL_ROM_CLOCK_LINE_OE),
    .sda_out(SERIAL_ROM_DATA_LINE_OUT),
    .sda_oe(SERIAL_ROM_DATA_LINE_OE)
  );

  // strap comes from a pin
  always @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      // pins stay released until the strap level is known
      off_s1_reg <= 1'b1;
      off_s2_reg <= 1'b1;
    end else begin
      off_s1_reg <= ROM_LOADER_DISABLE;
      off_s2_reg <= off_s1_reg;
    end
  end

  always @* begin
    cmd_next = `SECL_CMD_START;
    tx_next = 8'h00;
    case (state_reg)
      S_DEVW: begin
        cmd_next = `SECL_CMD_WRITE;
        tx_next = {`SECL_DEV_ADDR, 1'b0};
      end
      S_ADDR: begin
        cmd_next = `SECL_CMD_WRITE;
        tx_next = addr_reg;
      end
      S_WDAT: begin
        cmd_next = `SECL_CMD_WRITE;
        tx_next = wdat_reg;
      end
      S_DEVR: begin
        cmd_next = `SECL_CMD_WRITE;
        tx_next = {`SECL_DEV_ADDR, 1'b1};
      end
      S_READ: begin
        cmd_next = `SECL_CMD_READ;
      end
      S_STOP: begin
        cmd_next = `SECL_CMD_STOP;
      end
      default: begin
        cmd_next = `SECL_CMD_START;
      end
    endcase
  end

  always @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      state_reg <= S_BOOT;
      mode_reg <= M_LOAD;
      boot_reg <= 2'h0;
      idx_reg <= 4'h0;
      addr_reg <= `SECL_ROM_BASE;
      wdat_reg <= 8'h00;
      issued_reg <= 1'b0;
      go_reg <= 1'b0;
      cmd_reg <= `SECL_CMD_START;
      tx_reg <= 8'h00;
      nack_reg <= 1'b0;
      fail_reg <= 1'b0;
      abort_reg <= 1'b0;
      sub_stage_reg <= 32'h00000000;
      cfg_stage_reg <= 32'h00000000;
      subsys_reg <= DEF_SUBSYS;
      config_reg <= DEF_CONFIG;
      load_done_reg <= 1'b0;
      load_valid_reg <= 1'b0;
      present_reg <= 1'b0;
      ready_reg <= 1'b0;
      host_done_reg <= 1'b0;
      host_err_reg <= 1'b0;
      host_rdata_reg <= 8'h00;
    end else begin
      go_reg <= 1'b0;
      host_done_reg <= 1'b0;
      case (state_reg)
        S_BOOT: begin
          boot_reg <= boot_reg + 2'h1;
          if (boot_reg == `SECL_SYNC_CYC) begin
            if (off_s2_reg) begin
              load_done_reg <= 1'b1;
              ready_reg <= 1'b1;
              state_reg <= S_IDLE;
            end else begin
              mode_reg <= M_LOAD;
              addr_reg <= `SECL_ROM_BASE;
              idx_reg <= 4'h0;
              state_reg <= S_START;
            end
          end
        end
        S_IDLE: begin
          if (HOST_REQ && off_s2_reg) begin
            // pins are cut off, nothing to talk to
            host_done_reg <= 1'b1;
            host_err_reg <= 1'b1;
          end else if (HOST_REQ) begin
            ready_reg <= 1'b0;
            mode_reg <= HOST_WRITE ? M_WR : M_RD;
            addr_reg <= HOST_ADDR;
            wdat_reg <= HOST_WDATA;
            fail_reg <= 1'b0;
            state_reg <= S_START;
          end
        end
        default: begin
          if (!issued_reg) begin
            go_reg <= 1'b1;
            issued_reg <= 1'b1;
            cmd_reg <= cmd_next;
            tx_reg <= tx_next;
            nack_reg <= nack_next;
          end else if (eng_done) begin
            issued_reg <= 1'b0;
            case (state_reg)
              S_START: begin
                state_reg <= S_DEVW;
              end
              S_DEVW: begin
                if (mode_reg == M_LOAD) begin
                  present_reg <= eng_ack;
                end
                fail_reg <= ~eng_ack;
                state_reg <= eng_ack ? S_ADDR : S_STOP;
              end
              S_ADDR: begin
                fail_reg <= ~eng_ack;
                if (!eng_ack) begin
                  state_reg <= S_STOP;
                end else if (mode_reg == M_WR) begin
                  state_reg <= S_WDAT;
                end else begin
                  state_reg <= S_RSTART;
                end
              end
              S_WDAT: begin
                fail_reg <= ~eng_ack;
                state_reg <= S_STOP;
              end
              S_RSTART: begin
                state_reg <= S_DEVR;
              end
              S_DEVR: begin
                fail_reg <= ~eng_ack;
                state_reg <= eng_ack ? S_READ : S_STOP;
              end
              S_READ: begin
                idx_reg <= idx_reg + 4'h1;
                if (mode_reg != M_LOAD) begin
                  host_rdata_reg <= eng_rx;
                end else if (idx_reg == `SECL_HDR_IDX) begin
                  // one more byte is clocked with nack, the bus needs it
                  if (eng_rx != `SECL_HDR_SIG) begin
                    abort_reg <= 1'b1;
                  end
                end else if (idx_reg < `SECL_CFG_IDX) begin
                  sub_stage_reg <= put_byte(sub_stage_reg, sub_pos[1:0], eng_rx);
                end else begin
                  cfg_stage_reg <= put_byte(cfg_stage_reg, cfg_pos[1:0], eng_rx);
                end
                if (nack_reg) begin
                  state_reg <= S_STOP;
                end
              end
              S_STOP: begin
                state_reg <= S_IDLE;
                ready_reg <= 1'b1;
                if (mode_reg == M_LOAD) begin
                  load_done_reg <= 1'b1;
                  // staged so a failed load never half-updates
                  if (!fail_reg && !abort_reg) begin
                    load_valid_reg <= 1'b1;
                    subsys_reg <= sub_stage_reg;
                    config_reg <= cfg_stage_reg;
                  end
                end else begin
                  host_done_reg <= 1'b1;
                  host_err_reg <= fail_reg;
                end
              end
              default: begin
                state_reg <= S_IDLE;
              end
            endcase
          end
        end
      endcase
    end
  end
endmodule

// *** rtl/secl_regs.vh ***
`ifndef SECL_REGS_VH
`define SECL_REGS_VH

// core clock and two-wire quarter bit time
`define SECL_CLK_MHZ 40
`define SECL_QTR_NS 2500
`define SECL_QTR_CYC ((`SECL_QTR_NS * `SECL_CLK_MHZ + 999) / 1000)

// cycles allowed for the strap synchroniser to settle
`define SECL_SYNC_CYC 2'h3

// rom addressing and image layout
`define SECL_DEV_ADDR 7'h50
`define SECL_HDR_SIG 8'h55
`define SECL_ROM_BASE 8'h00
`define SECL_HDR_IDX 4'h0
`define SECL_SUB_IDX 4'h1
`define SECL_CFG_IDX 4'h5
`define SECL_LAST_IDX 4'h8

// configuration space homes of the loaded words
`define SECL_SUBSYS_OFS 8'hfc
`define SECL_CONFIG_LOAD_REGISTER_OFS 8'hf0

// bit engine commands
`define SECL_CMD_START 2'h0
`define SECL_CMD_STOP 2'h1
`define SECL_CMD_WRITE 2'h2
`define SECL_CMD_READ 2'h3

// ninth bit slot of a byte
`define SECL_ACK_BIT 4'h8

`endif

// *** rtl/secl_wire_engine.v ***
`timescale 1ns/1ps
`include "secl_regs.vh"
module secl_wire_engine #(
  parameter QTR_CYC = `SECL_QTR_CYC
) (
  input wire clk,
  input wire rst_n,
  input wire pins_off,
  input wire cmd_valid,
  input wire [1:0] cmd,
  input wire [7:0] tx_byte,
  input wire tx_nack,
  input wire sda_pin,
  output wire done,
  output wire acked,
  output wire [7:0] rx_byte,
  output wire scl_out,
  output wire scl_oe,
  output wire sda_out,
  output wire sda_oe
);
  localparam [15:0] QTR_LAST = QTR_CYC[15:0] - 16'h0001;

  reg sda_s1_reg;
  reg sda_s2_reg;
  reg busy_reg;
  reg done_reg;
  reg ack_reg;
  reg scl_reg;
  reg low_reg;
  reg scl_oe_reg;
  reg sda_oe_reg;
  reg nack_reg;
  reg [1:0] op_reg;
  reg [1:0] q_reg;
  reg [3:0] bit_reg;
  reg [7:0] sh_reg;
  reg [15:0] cnt_reg;
  wire tick;

  assign tick = busy_reg && (cnt_reg == QTR_LAST);
  assign done = done_reg;
  assign acked = ack_reg;
  assign rx_byte = sh_reg;
  assign scl_out = scl_reg;
  assign scl_oe = scl_oe_reg;
  // open drain: only ever pulls low
  assign sda_out = 1'b0;
  assign sda_oe = sda_oe_reg;

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sda_s1_reg <= 1'b1;
      sda_s2_reg <= 1'b1;
    end else begin
      sda_s1_reg <= sda_pin;
      sda_s2_reg <= sda_s1_reg;
    end
  end

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      busy_reg <= 1'b0;
      done_reg <= 1'b0;
      ack_reg <= 1'b0;
      scl_reg <= 1'b1;
      low_reg <= 1'b0;
      scl_oe_reg <= 1'b0;
      sda_oe_reg <= 1'b0;
      nack_reg <= 1'b0;
      op_reg <= `SECL_CMD_START;
      q_reg <= 2'h0;
      bit_reg <= 4'h0;
      sh_reg <= 8'h00;
      cnt_reg <= 16'h0000;
    end else begin
      done_reg <= 1'b0;
      // disabled means both pins let go entirely
      scl_oe_reg <= ~pins_off;
      sda_oe_reg <= low_reg & ~pins_off;
      if (!busy_reg) begin
        cnt_reg <= 16'h0000;
        if (cmd_valid) begin
          busy_reg <= 1'b1;
          op_reg <= cmd;
          sh_reg <= tx_byte;
          nack_reg <= tx_nack;
          q_reg <= 2'h0;
          bit_reg <= 4'h0;
          scl_reg <= 1'b0;
        end
      end else if (!tick) begin
        cnt_reg <= cnt_reg + 16'h0001;
      end else begin
        cnt_reg <= 16'h0000;
        q_reg <= q_reg + 2'h1;
        case (q_reg)
          2'h0: begin
            // data moves only a full quarter after the clock fell
            if (op_reg == `SECL_CMD_START) begin
              low_reg <= 1'b0;
            end else if (op_reg == `SECL_CMD_STOP) begin
              low_reg <= 1'b1;
            end else if (bit_reg == `SECL_ACK_BIT) begin
              low_reg <= (op_reg == `SECL_CMD_READ) & ~nack_reg;
            end else begin
              low_reg <= (op_reg == `SECL_CMD_WRITE) & ~sh_reg[7];
            end
          end
          2'h1: begin
            scl_reg <= 1'b1;
          end
          2'h2: begin
            // edges with clock high are framing only
            if (op_reg == `SECL_CMD_START) begin
              low_reg <= 1'b1;
            end else if (op_reg == `SECL_CMD_STOP) begin
              low_reg <= 1'b0;
            end
          end
          default: begin
            if (op_reg != `SECL_CMD_STOP) begin
              scl_reg <= 1'b0;
            end
            if (op_reg[1] && bit_reg != `SECL_ACK_BIT) begin
              sh_reg <= {sh_reg[6:0], sda_s2_reg};
              bit_reg <= bit_reg + 4'h1;
            end else begin
              busy_reg <= 1'b0;
              done_reg <= 1'b1;
              ack_reg <= ~sda_s2_reg;
            end
          end
        endcase
      end
    end
  end
endmodule

// *** test/secl_loader_asserts.sv ***
`timescale 1ns/1ps
module secl_loader_asserts #(
  parameter int QTR_CYC = 100,
  parameter [31:0] DEF_SUBSYS = 32'h00000000,
  parameter [31:0] DEF_CONFIG = 32'h00000000
) (
  input logic CLK,
  input logic RST_N,
  input logic ROM_LOADER_DISABLE,
  input logic SERIAL_ROM_DATA_LINE_OE,
  input logic SERIAL_ROM_CLOCK_LINE_OUT,
  input logic SERIAL_ROM_CLOCK_LINE_OE,
  input logic HOST_REQ,
  input logic HOST_READY,
  input logic HOST_DONE,
  input logic HOST_ERR,
  input logic LOAD_DONE,
  input logic LOAD_VALID,
  input logic ROM_PRESENT,
  input logic [31:0] SUBSYSTEM_IDS,
  input logic [31:0] CONFIG_LOAD_REGISTER
);
  localparam int QW = 4 * QTR_CYC + 8;
  // an undriven clock line floats high on its pull-up
  wire scl_hi = SERIAL_ROM_CLOCK_LINE_OUT | ~SERIAL_ROM_CLOCK_LINE_OE;
  wire scl_oe = SERIAL_ROM_CLOCK_LINE_OE;
  wire sda_oe = SERIAL_ROM_DATA_LINE_OE;
  default clocking @(posedge CLK); endclocking
  default disable iff (!RST_N);
  a_data_clk_low: assert property ($changed(sda_oe) && scl_hi && scl_oe |-> $past(scl_hi) && $past(scl_hi, 2))
    else $error("data moved at a clock edge");
  a_start_then_low: assert property ($rose(sda_oe) && scl_hi && scl_oe |-> scl_hi[*2] ##[1:QW] !scl_hi)
    else $error("start not followed by clock low");
  a_stop_holds: assert property ($fell(sda_oe) && scl_hi && scl_oe |=> scl_hi[*4])
    else $error("clock left high level after stop");
  a_strap_off: assert property (ROM_LOADER_DISABLE[*5] |-> !scl_oe && !sda_oe)
    else $error("pins driven while loader disabled");
  a_strap_err: assert property (ROM_LOADER_DISABLE[*5] ##0 (HOST_REQ && HOST_READY) |=> HOST_DONE && HOST_ERR && HOST_READY)
    else $error("disabled request not refused at once");
  a_take_busy: assert property ((!ROM_LOADER_DISABLE)[*5] ##0 (HOST_REQ && HOST_READY) |=> !HOST_READY && !HOST_DONE)
    else $error("request not taken");
  a_done_after_busy: assert property ((!ROM_LOADER_DISABLE)[*5] ##0 HOST_DONE |-> !$past(HOST_READY))
    else $error("done without a busy phase");
  a_load_stays: assert property (LOAD_DONE |=> LOAD_DONE)
    else $error("load done dropped");
  a_valid_parts: assert property (LOAD_VALID |=> LOAD_DONE && ROM_PRESENT)
    else $error("valid load without rom");
  a_bad_default: assert property (LOAD_DONE && $past(LOAD_DONE, 2) && !LOAD_VALID |->
      SUBSYSTEM_IDS == DEF_SUBSYS && CONFIG_LOAD_REGISTER == DEF_CONFIG)
    else $error("defaults lost without a valid load");
  a_ids_frozen: assert property (LOAD_DONE && $past(LOAD_DONE, 2) |-> $stable(SUBSYSTEM_IDS) && $stable(CONFIG_LOAD_REGISTER))
    else $error("loaded words changed after load");
  a_probe_boot: assert property ($rose(RST_N) && !ROM_LOADER_DISABLE |-> ##[1:QW] scl_oe ##[1:QW] sda_oe)
    else $error("no probe after reset");
  c_good_boot: cover property ($rose(LOAD_VALID));
  c_host_err: cover property (HOST_DONE && HOST_ERR);
  c_host_ok: cover property (HOST_DONE && !HOST_ERR);
endmodule

// *** test/secl_rom_model.sv ***
`timescale 1ns/1ps
module secl_rom_model (
  input wire scl,
  input wire sda,
  input wire present,
  output wire sda_low
);
  reg [7:0] mem [0:255];
  reg [7:0] sh = 8'h00, ptr = 8'h77;
  reg [3:0] bc = 4'h0;
  reg [1:0] ph = 2'h0;
  reg act = 0, tx = 0, rdn = 0, drv = 0;
  integer nread = 0;
  assign sda_low = drv;
  always @(negedge sda) if (scl) begin
    act = 1; bc = 0; ph = 0; tx = 0; rdn = 0; drv = 0;
  end
  always @(posedge sda) if (scl) act = 0;
  always @(posedge scl) if (act) begin
    if (bc < 8 && !tx) sh = {sh[6:0], sda};
    if (bc == 8 && tx) begin
      ptr = ptr + 1;
      nread = nread + 1;
      if (sda) act = 0;
    end
    bc = bc + 1;
  end
  // drive only after the clock falls, so data never moves while it is high
  always @(negedge scl) if (act) begin
    if (bc == 8) begin
      if (tx) drv = 0;
      else if (ph == 0) begin
        if (sh[7:1] == 7'h50 && present) begin
          drv = 1; ph = 1; rdn = sh[0];
        end else act = 0;
      end else begin
        drv = 1;
        if (ph == 1) ptr = sh;
        else begin
          mem[ptr] = sh; ptr = ptr + 1;
        end
        ph = 2;
      end
    end else begin
      if (bc == 9) begin
        bc = 0; tx = tx | rdn;
      end
      drv = tx & ~mem[ptr][3'd7 - bc[2:0]];
    end
  end
endmodule

// *** test/secl_loader_bench.sv ***
`timescale 1ns/1ps
module secl_loader_bench;
  localparam int QTR_CYC = 4;
  logic CLK = 0, RST_N = 0, ROM_LOADER_DISABLE = 0, HOST_REQ = 0, HOST_WRITE = 0, present = 1;
  logic [7:0] HOST_ADDR = 8'h00, HOST_WDATA = 8'h00, a, d;
  wire SERIAL_ROM_DATA_LINE_IN, SERIAL_ROM_DATA_LINE_OUT, SERIAL_ROM_DATA_LINE_OE, rom_low;
  wire SERIAL_ROM_CLOCK_LINE_OUT, SERIAL_ROM_CLOCK_LINE_OE, HOST_READY, HOST_DONE, HOST_ERR;
  wire LOAD_DONE, LOAD_VALID, ROM_PRESENT;
  wire [7:0] HOST_RDATA;
  wire [31:0] SUBSYSTEM_IDS, CONFIG_LOAD_REGISTER;
  int num_errors = 0, checked = 0;
  logic [9:0] exp_host [$];
  logic [65:0] exp_boot [$];
  logic [65:0] b;
  logic [9:0] h;
  logic [7:0] img [0:8];
  logic d1 = 0, d2 = 0;
  // data line is open drain, clock is driven high and low when enabled; both have pull-ups
  wire scl = SERIAL_ROM_CLOCK_LINE_OE ? SERIAL_ROM_CLOCK_LINE_OUT : 1'b1;
  assign SERIAL_ROM_DATA_LINE_IN = ((SERIAL_ROM_DATA_LINE_OE & ~SERIAL_ROM_DATA_LINE_OUT) | rom_low) ? 1'b0 : 1'b1;
  secl_loader #(.QTR_CYC(QTR_CYC), .DEF_SUBSYS(32'h1234abcd), .DEF_CONFIG(32'h0badf00d)) i_dut (.*);
  secl_rom_model i_rom (.scl(scl), .sda(SERIAL_ROM_DATA_LINE_IN), .present(present), .sda_low(rom_low));
  always #12.5 CLK = ~CLK;
  task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic print_verdict;
    $display("checks %0d errors %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // 0 load done, 1 host done, 2 host ready
  task automatic wait_for(int which);
    for (int i = 0; i < 20000; i++) begin
      @(negedge CLK);
      if ((which == 0 ? LOAD_DONE : which == 1 ? HOST_DONE : HOST_READY) === 1'b1) return;
    end
    num_errors++;
    print_verdict();
  endtask
  task automatic boot(logic strap, logic pres, logic [7:0] hdr);
    logic ok;
    int cnt;
    img[0] = hdr;
    for (int k = 1; k < 9; k++) img[k] = $urandom;
    for (int k = 0; k < 9; k++) i_rom.mem[k] = img[k];
    i_rom.nread = 0;
    i_rom.ptr = 8'h77;
    ok = !strap && pres && hdr == 8'h55;
    // a bad header costs one more byte, read with a nack
    cnt = ok ? 9 : (pres && !strap) ? 2 : 0;
    exp_boot.push_back({ok, pres & !strap, ok ? {img[4], img[3], img[2], img[1]} : 32'h1234abcd,
                        ok ? {img[8], img[7], img[6], img[5]} : 32'h0badf00d});
    @(posedge CLK);
    #2 {RST_N, ROM_LOADER_DISABLE, present} = {1'b0, strap, pres};
    repeat (3) @(posedge CLK);
    #2 RST_N = 1;
    wait_for(0);
    repeat (4) @(negedge CLK);
    check("bytes read", i_rom.nread, cnt);
    check("rom pointer", i_rom.ptr, cnt ? cnt : 8'h77);
  endtask
  task automatic host(logic wr, logic [7:0] ad, logic [7:0] wd, logic err, logic cmp, logic [7:0] rd);
    exp_host.push_back({cmp, err, rd});
    wait_for(2);
    @(posedge CLK);
    #2 {HOST_REQ, HOST_WRITE, HOST_ADDR, HOST_WDATA} = {1'b1, wr, ad, wd};
    @(posedge CLK);
    #2 HOST_REQ = 0;
    wait_for(1);
  endtask
  always @(negedge CLK) begin
    if (LOAD_DONE === 1'b1 && d1 && !d2) begin
      if (exp_boot.size() == 0) check("boot queue", 1, 0);
      else begin
        b = exp_boot.pop_front();
        check("load valid", LOAD_VALID, b[65]);
        check("rom present", ROM_PRESENT, b[64]);
        check("subsystem ids", SUBSYSTEM_IDS, b[63:32]);
        check("config load", CONFIG_LOAD_REGISTER, b[31:0]);
      end
    end
    if (HOST_DONE === 1'b1) begin
      if (exp_host.size() == 0) check("host queue", 1, 0);
      else begin
        h = exp_host.pop_front();
        check("host err", HOST_ERR, h[8]);
        if (h[9]) check("host rdata", HOST_RDATA, h[7:0]);
      end
    end
    d2 <= d1;
    d1 <= LOAD_DONE;
  end
  initial begin
    void'($urandom(57809));
    boot(0, 1, 8'h55);
    a = 8'h10 + 8'($urandom_range(0, 200));
    d = $urandom;
    host(1, a, d, 0, 0, 8'h00);
    check("rom cell", i_rom.mem[a], d);
    host(0, a, 8'h00, 0, 1, d);
    host(0, 8'h03, 8'h00, 0, 1, img[3]);
    boot(0, 1, 8'haa);
    boot(0, 0, 8'h55);
    host(0, 8'h02, 8'h00, 1, 0, 8'h00);
    boot(1, 1, 8'h55);
    host(0, 8'h01, 8'h00, 1, 0, 8'h00);
    check("clock enable", SERIAL_ROM_CLOCK_LINE_OE, 0);
    check("data enable", SERIAL_ROM_DATA_LINE_OE, 0);
    boot(0, 1, 8'h55);
    repeat (4) @(negedge CLK);
    check("queues left", exp_boot.size() + exp_host.size(), 0);
    print_verdict();
  end
endmodule
bind secl_loader secl_loader_asserts #(.QTR_CYC(QTR_CYC), .DEF_SUBSYS(DEF_SUBSYS), .DEF_CONFIG(DEF_CONFIG)) i_chk (.*);
